//--- design/ivx_ctrl.sv
// vector placement control, external and pin-change interrupt detection
`timescale 1ns/1ns
module ivx_ctrl
    import ivx_pkg::*;
#(
    parameter int FLASH_WORDS    = 8192,
    parameter int BOOT_MIN_WORDS = 128
)
(
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    input  wire logic [7:0]                    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    input  wire ivx_core_t                     core,
    input  wire ivx_fuse_t                     fuse,
    input  wire logic                          io_clk_run,
    input  wire logic                          ext_irq_pin_a,
    input  wire logic                          ext_irq_pin_b,
    input  wire logic [23:0]                   pin_change_inputs,
    output logic      [$clog2(FLASH_WORDS)-1:0] vector_base,
    output logic      [IVX_NUM_REQ-1:0]        irq_req,
    output logic                               irq_blocked,
    output logic                               wake_req,
    output logic                               pullup_disable
);

    localparam int AW = $clog2(FLASH_WORDS);

    // sizes the vector base logic cannot serve stop elaboration
    if (FLASH_WORDS != (1 << AW) || BOOT_MIN_WORDS < 1
        || (BOOT_MIN_WORDS << 3) > FLASH_WORDS)
    begin : g_size_check
        $error("ivx_ctrl: flash and boot sizes must be powers of two that fit");
    end

    ivx_state_t st;
    ivx_state_t next_st;

    logic [5:0]  idx;
    logic        take;
    logic        wr;
    logic [7:0]  wbyte;
    logic [1:0]  ext_pin;
    logic [1:0]  ext_edge;
    logic [1:0]  ext_level;
    logic [1:0]  ext_clr;
    logic [2:0]  pc_clr;
    logic [23:0] pc_valid_mask;
    logic [23:0] pc_change;
    logic [2:0]  pc_group_hit;
    logic        vce_set_now;
    logic        lock_block;
    logic [AW-1:0] boot_words;
    logic [IVX_NUM_REQ-1:0] raw_req;
    logic [IVX_NUM_REQ-1:0] req_en;
    logic [7:0]  rd_byte;

    assign idx   = avs_address[7:2];
    // one wait state: request taken at the edge where waitrequest is low
    assign take  = (avs_read || avs_write) && st.ack;
    assign wr    = take && avs_write && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
    assign avs_readdata    = {24'h00_0000, st.rdata};
    assign pullup_disable  = st.pullup_disable;
    // a request held past its answer starts a fresh wait cycle

    assign ext_pin = {ext_irq_pin_b, ext_irq_pin_a};
    // group 1 bit 15 does not exist and never counts
    assign pc_valid_mask = st.pc_mask & {8'hFF, IVX_PC1_VALID, 8'hFF};

    assign boot_words = AW'(BOOT_MIN_WORDS << (2'd3 - fuse.boot_size_fuses));

    assign vector_base = st.vector_select ? AW'(FLASH_WORDS - int'(boot_words))
                                          : '0;

    assign lock_block = (st.vector_select && fuse.app_lock_bit && !core.exec_in_boot)
                     || (!st.vector_select && fuse.boot_lock_bit && core.exec_in_boot);

    assign vce_set_now = wr && (idx == IVX_IDX_MCU_CONTROL) && wbyte[IVX_BIT_VCE];
    // lock blocking shows on irq_blocked too, so the core sees one gate

    // block from the cycle enable is set until the window lapses, or after a select write until after the next instruction
    // blocking is local; the core global enable is only read here
    assign irq_blocked = vce_set_now || st.vector_change_enable
                      || (st.post_cnt != 2'h0) || lock_block;

    always_comb
    begin
        ext_edge  = 2'b00;
        ext_level = 2'b00;
        ext_clr   = 2'b00;
        for (int i = 0; i < 2; i++)
        begin
            // compare against the sampled value of the previous cycle
            // edges only while the io clock runs
            // deep sleep stops io clock, so edges are lost there
            if (st.primed && io_clk_run)
            begin
                case (st.sense[2*i +: 2])
                    IVX_SENSE_ANY:  ext_edge[i] = ext_pin[i] ^ st.ext_prev[i];
                    IVX_SENSE_FALL: ext_edge[i] = !ext_pin[i] && st.ext_prev[i];
                    IVX_SENSE_RISE: ext_edge[i] = ext_pin[i] && !st.ext_prev[i];
                    default:        ext_edge[i] = 1'b0;
                endcase
            end
            ext_level[i] = (st.sense[2*i +: 2] == IVX_SENSE_LOW) && !ext_pin[i];
            ext_clr[i] = (wr && (idx == IVX_IDX_EXT_FLAG) && wbyte[i])
                      || (core.irq_ack && (core.irq_ack_id == 3'(i)));
        end
    end

    always_comb
    begin
        // pins are read whatever their direction
        pc_change = (pin_change_inputs ^ st.pc_prev) & pc_valid_mask;
        for (int g = 0; g < 3; g++)
        begin
            pc_group_hit[g] = st.primed && (pc_change[8*g +: 8] != 8'h00);
            pc_clr[g] = (wr && (idx == IVX_IDX_PC_FLAG) && wbyte[g])
                     || (core.irq_ack && (core.irq_ack_id == 3'(g) + IVX_REQ_PC0));
        end
    end

    // pin change wake path bypasses the io clock
    // low level wake path bypasses the io clock
    // wake is combinational so it works with every clock stopped
    assign wake_req = |(ext_level & st.ext_en) | |(pc_group_hit & st.pc_en);

    // level requests vanish with the level; wake alone does not latch one
    assign raw_req = {st.pc_flag,
                      (st.sense[3:2] == IVX_SENSE_LOW) ? ext_level[1] : st.ext_flag[1],
                      (st.sense[1:0] == IVX_SENSE_LOW) ? ext_level[0] : st.ext_flag[0]};
    assign req_en  = {st.pc_en, st.ext_en};

    // own enable, global enable and no blocking
    assign irq_req = (raw_req & req_en)
                   & {IVX_NUM_REQ{core.global_irq_enable && !irq_blocked}};

    always_comb
    begin
        case (idx)
            IVX_IDX_MCU_CONTROL:
                rd_byte = {3'b000, st.pullup_disable, 2'b00,
                           st.vector_select, st.vector_change_enable};
            IVX_IDX_SENSE_CTRL: rd_byte = {4'h0, st.sense};
            IVX_IDX_EXT_MASK:   rd_byte = {6'h00, st.ext_en};
            IVX_IDX_EXT_FLAG:   rd_byte = {6'h00, st.ext_flag};
            IVX_IDX_PC_CTRL:    rd_byte = {5'h00, st.pc_en};
            IVX_IDX_PC_FLAG:    rd_byte = {5'h00, st.pc_flag};
            IVX_IDX_PC_MASK0:   rd_byte = pc_valid_mask[7:0];
            IVX_IDX_PC_MASK1:   rd_byte = pc_valid_mask[15:8];
            IVX_IDX_PC_MASK2:   rd_byte = pc_valid_mask[23:16];
            IVX_IDX_STATUS:     rd_byte = {6'h00, lock_block, irq_blocked};
            // unmapped reads return zero
            default:            rd_byte = 8'h00;
        endcase
    end

    always_comb
    begin
        next_st = st;
        next_st.ack = (avs_read || avs_write) && !st.ack;
        if ((avs_read || avs_write) && !st.ack)
        begin
            next_st.rdata = rd_byte;
        end
        next_st.primed   = 1'b1;
        next_st.ext_prev = ext_pin;
        next_st.pc_prev  = pin_change_inputs;

        // unwritten window runs down over four cycles
        // hardware clears change enable after four cycles
        if (st.vector_change_enable)
        begin
            next_st.vce_cnt = st.vce_cnt - 3'h1;
            if (st.vce_cnt == 3'h1)
            begin
                next_st.vector_change_enable = 1'b0;
            end
        end
        if (st.post_cnt != 2'h0 && core.instr_done)
        begin
            next_st.post_cnt = st.post_cnt - 2'h1;
        end

        if (wr)
        begin
            case (idx)
                IVX_IDX_MCU_CONTROL:
                begin
                    next_st.pullup_disable = wbyte[IVX_BIT_PUD];
                    // timed two-step sequence guards the select bit
                    if (wbyte[IVX_BIT_VCE])
                    begin
                        next_st.vector_change_enable = 1'b1;
                        next_st.vce_cnt = IVX_VCE_CNT_INIT;
                    end
                    else if (st.vector_change_enable)
                    begin
                        // select write ends the window at once
                        next_st.vector_select = wbyte[IVX_BIT_VSEL];
                        next_st.vector_change_enable = 1'b0;
                        next_st.vce_cnt = 3'h0;
                        // hold through the write and the one after
                        next_st.post_cnt = IVX_POST_INSTR;
                    end
                end
                IVX_IDX_SENSE_CTRL: next_st.sense = wbyte[3:0];
                IVX_IDX_EXT_MASK:   next_st.ext_en = wbyte[1:0];
                IVX_IDX_PC_CTRL:    next_st.pc_en = wbyte[2:0];
                IVX_IDX_PC_MASK0:   next_st.pc_mask[7:0] = wbyte;
                IVX_IDX_PC_MASK1:   next_st.pc_mask[15:8] = wbyte & IVX_PC1_VALID;
                IVX_IDX_PC_MASK2:   next_st.pc_mask[23:16] = wbyte;
                default:            next_st.pc_mask = st.pc_mask;
            endcase
        end

        // set beats clear; level mode keeps the flag at zero
        for (int i = 0; i < 2; i++)
        begin
            if (next_st.sense[2*i +: 2] == IVX_SENSE_LOW)
            begin
                next_st.ext_flag[i] = 1'b0;
            end
            else
            begin
                next_st.ext_flag[i] = ext_edge[i] || (st.ext_flag[i] && !ext_clr[i]);
            end
        end
        // pin change flags: set beats clear as well
        next_st.pc_flag = pc_group_hit | (st.pc_flag & ~pc_clr);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st <= '{ack: 1'b0, rdata: IVX_RST_BYTE, vector_select: 1'b0,
                    vector_change_enable: 1'b0, vce_cnt: 3'h0, post_cnt: 2'h0,
                    pullup_disable: 1'b0, sense: 4'h0, ext_en: 2'h0,
                    ext_flag: 2'h0, pc_en: 3'h0, pc_flag: 3'h0,
                    pc_mask: IVX_RST_PC_MASK, ext_prev: 2'h0,
                    pc_prev: 24'h00_0000, primed: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule : ivx_ctrl

//--- dv/ivx_chk.sv
// port checker for the vector placement and irq block
`timescale 1ns/1ns
module ivx_chk
    import ivx_pkg::*;
#(
    parameter int FLASH_WORDS    = 8192,
    parameter int BOOT_MIN_WORDS = 128
)
(
    input wire logic                           clk_sys,
    input wire logic                           rst_b,
    input wire logic [7:0]                     avs_address,
    input wire logic                           avs_read,
    input wire logic                           avs_write,
    input wire logic [31:0]                    avs_writedata,
    input wire logic [3:0]                     avs_byteenable,
    input wire logic [31:0]                    avs_readdata,
    input wire logic                           avs_waitrequest,
    input wire ivx_core_t                      core,
    input wire ivx_fuse_t                      fuse,
    input wire logic                           io_clk_run,
    input wire logic                           ext_irq_pin_a,
    input wire logic                           ext_irq_pin_b,
    input wire logic [23:0]                    pin_change_inputs,
    input wire logic [$clog2(FLASH_WORDS)-1:0] vector_base,
    input wire logic [IVX_NUM_REQ-1:0]         irq_req,
    input wire logic                           irq_blocked,
    input wire logic                           wake_req,
    input wire logic                           pullup_disable
);
    logic [3:0] sense;
    logic [1:0] ext_en;
    logic       wr_ok;
    logic       ok;
    // shadow of sense and enable, since the checker sees ports only
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign ok = core.global_irq_enable && !irq_blocked
             && !fuse.app_lock_bit && !fuse.boot_lock_bit;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            sense <= 4'h0;
        else if (wr_ok && avs_address[7:2] == IVX_IDX_SENSE_CTRL)
            sense <= avs_writedata[3:0];
        if (!rst_b)
            ext_en <= 2'h0;
        else if (wr_ok && avs_address[7:2] == IVX_IDX_EXT_MASK)
            ext_en <= avs_writedata[1:0];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus wait longer than one cycle");
    vce_block_a: assert property (wr_ok && avs_address[7:2] == IVX_IDX_MCU_CONTROL
        && avs_writedata[0] |-> irq_blocked ##1 irq_blocked [*4])
        else $error("change window unblocked");
    req_gate_a: assert property (!core.global_irq_enable || irq_blocked
        |-> irq_req == '0) else $error("request while gated");
    base_value_a: assert property (vector_base == '0 || int'(vector_base) ==
        FLASH_WORDS - (BOOT_MIN_WORDS << (3 - fuse.boot_size_fuses)))
        else $error("bad vector base");
    app_lock_a: assert property (fuse.app_lock_bit && vector_base != '0 &&
        !core.exec_in_boot |-> irq_req == '0) else $error("request in locked application");
    boot_lock_a: assert property (fuse.boot_lock_bit && vector_base == '0 &&
        core.exec_in_boot |-> irq_req == '0) else $error("request in locked boot section");
    level_req_a: assert property (sense[1:0] == IVX_SENSE_LOW && ext_en[0] &&
        !ext_irq_pin_a && ok |-> irq_req[0] && wake_req) else $error("level request missing");
    fall_req_a: assert property ($fell(ext_irq_pin_a) && sense[1:0] == IVX_SENSE_FALL &&
        ext_en[0] && io_clk_run |=> irq_req[0] || !ok) else $error("falling edge missed");
    cover property (wr_ok && avs_address[7:2] == IVX_IDX_MCU_CONTROL && avs_writedata[0]);
    cover property (irq_req[4:2] != 3'h0);
    cover property (core.irq_ack);
endmodule : ivx_chk

bind ivx_ctrl ivx_chk #(.FLASH_WORDS(FLASH_WORDS), .BOOT_MIN_WORDS(BOOT_MIN_WORDS)) ivx_chk_inst (
    .clk_sys, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .core, .fuse, .io_clk_run, .ext_irq_pin_a, .ext_irq_pin_b,
    .pin_change_inputs, .vector_base, .irq_req, .irq_blocked, .wake_req, .pullup_disable);

//--- dv/ivx_core_model.sv
// core side model: retires instructions and enters handlers
`timescale 1ns/1ns
module ivx_core_model
    import ivx_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    input  wire logic [IVX_NUM_REQ-1:0] irq_req,
    input  wire logic                   gie,
    input  wire logic                   ack_en,
    input  wire logic                   in_boot,
    output ivx_core_t                   core
);
    logic ph = 1'b0;
    int   k;
    initial core = '0;
    always @(posedge clk_sys)
    begin
        ph <= !ph && rst_b;
        // global enable owned by core only
        core.global_irq_enable <= gie;
        core.exec_in_boot      <= in_boot;
        core.instr_done        <= ph;
        core.irq_ack           <= 1'b0;
        if (rst_b && ack_en && !core.irq_ack && irq_req != '0)
        begin
            for (k = IVX_NUM_REQ - 1; k >= 0; k--)
                if (irq_req[k])
                    core.irq_ack_id <= 3'(k);
            core.irq_ack <= 1'b1;
        end
    end
endmodule : ivx_core_model

//--- dv/test_irq_vector_place_ext_irq.sv
// self-checking bench for vector placement and external irq detection
`timescale 1ns/1ns
module test_irq_vector_place_ext_irq
    import ivx_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    ivx_core_t   core;
    ivx_fuse_t   fuse = '0;
    logic        io_clk_run = 1'b1;
    logic        ext_irq_pin_a = 1'b1;
    logic        ext_irq_pin_b = 1'b1;
    logic [23:0] pin_change_inputs = 24'h00_0000;
    logic [12:0] vector_base;
    logic [4:0]  irq_req;
    logic        irq_blocked;
    logic        wake_req;
    logic        pullup_disable;
    logic        in_boot = 1'b0;
    logic        gie = 1'b0;
    logic        ack_en = 1'b0;
    logic [7:0]  rd;
    int          err_count = 0;
    int          n_compared = 0;
    int          seed = 32'h9c99;
    int          cycles = 0;
    int          i, m, p, msk, e;

    ivx_ctrl ivx_ctrl_inst (.clk_sys, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .core, .fuse,
        .io_clk_run, .ext_irq_pin_a, .ext_irq_pin_b, .pin_change_inputs, .vector_base,
        .irq_req, .irq_blocked, .wake_req, .pullup_disable);
    ivx_core_model ivx_core_model_inst (.clk_sys, .rst_b, .irq_req, .gie, .ack_en, .in_boot,
        .core);

    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            complete_run;
        end
    end

    task automatic complete_run;
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge clk_sys);
        avs_address   <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, wd};
        avs_write     <= wr;
        avs_read      <= !wr;
        // waitrequest and read data taken as they stand at the edge
        do
        begin
            @(posedge clk_sys);
        end
        while (avs_waitrequest);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : tick

    initial
    begin
        fuse.boot_size_fuses = 2'($random(seed));
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (i = 32; i < 64; i++)
        begin
            bus(1'b0, 6'(i), 8'h00);
            check(rd, 32'h0000_0000);
        end
        gie <= 1'b1;
        bus(1'b1, IVX_IDX_MCU_CONTROL, 8'h01);
        bus(1'b1, IVX_IDX_MCU_CONTROL, 8'h02);
        tick(0);
        check(irq_blocked, 1);
        check(vector_base, 8192 - (128 << (3 - fuse.boot_size_fuses)));
        tick(8);
        check(irq_blocked, 0);
        bus(1'b1, IVX_IDX_MCU_CONTROL, 8'h01);
        tick(3);
        check(irq_blocked, 1);
        tick(1);
        check(irq_blocked, 0);
        bus(1'b1, IVX_IDX_MCU_CONTROL, 8'h10);
        bus(1'b0, IVX_IDX_MCU_CONTROL, 8'h00);
        check(rd, 32'h0000_0012);
        check(pullup_disable, 1);
        bus(1'b1, IVX_IDX_MCU_CONTROL, 8'h01);
        bus(1'b1, IVX_IDX_MCU_CONTROL, 8'h00);
        tick(8);
        check(vector_base, 0);
        bus(1'b1, IVX_IDX_EXT_MASK, 8'h01);
        for (m = 0; m < 4; m++)
        begin
            bus(1'b1, IVX_IDX_SENSE_CTRL, 8'(m));
            bus(1'b1, IVX_IDX_EXT_FLAG, 8'h03);
            ext_irq_pin_a <= 1'b0;
            tick(2);
            check(irq_req[0], m != 3);
            @(posedge clk_sys);
            ext_irq_pin_a <= 1'b1;
            tick(2);
            check(irq_req[0], m != 0);
            bus(1'b0, IVX_IDX_EXT_FLAG, 8'h00);
            check(rd, m != 0);
        end
        bus(1'b1, IVX_IDX_SENSE_CTRL, 8'h02);
        bus(1'b1, IVX_IDX_EXT_FLAG, 8'h03);
        io_clk_run    <= 1'b0;
        ext_irq_pin_a <= 1'b0;
        tick(2);
        check(irq_req[0], 0);
        @(posedge clk_sys);
        ext_irq_pin_a <= 1'b1;
        io_clk_run    <= 1'b1;
        gie           <= 1'b0;
        @(posedge clk_sys);
        ext_irq_pin_a <= 1'b0;
        tick(3);
        check(irq_req[0], 0);
        @(posedge clk_sys);
        gie <= 1'b1;
        tick(2);
        check(irq_req[0], 1);
        @(posedge clk_sys);
        ack_en <= 1'b1;
        tick(4);
        check(irq_req[0], 0);
        @(posedge clk_sys);
        ack_en <= 1'b0;
        bus(1'b1, IVX_IDX_PC_CTRL, 8'h07);
        for (i = 0; i < 12; i++)
        begin
            msk = $random(seed);
            bus(1'b1, IVX_IDX_PC_MASK0, 8'(msk));
            bus(1'b1, IVX_IDX_PC_MASK1, 8'(msk >> 8));
            bus(1'b1, IVX_IDX_PC_MASK2, 8'(msk >> 16));
            bus(1'b1, IVX_IDX_PC_FLAG, 8'h07);
            p = {$random(seed)} % 24;
            pin_change_inputs[p] <= !pin_change_inputs[p];
            e = (p != 15 && msk[p]) ? (1 << (p / 8)) : 0;
            tick(0);
            check(wake_req, e != 0);
            tick(1);
            check(irq_req[4:2], e);
        end
        bus(1'b1, IVX_IDX_EXT_MASK, 8'h03);
        bus(1'b1, IVX_IDX_SENSE_CTRL, 8'h00);
        ext_irq_pin_b <= 1'b0;
        tick(0);
        check(irq_req[1:0], 2'b11);
        check(wake_req, 1);
        @(posedge clk_sys);
        fuse.boot_lock_bit <= 1'b1;
        in_boot            <= 1'b1;
        tick(1);
        check(irq_req, 0);
        bus(1'b0, IVX_IDX_STATUS, 8'h00);
        check(rd, 32'h0000_0003);
        in_boot <= 1'b0;
        fuse    <= {2'b10, fuse.boot_size_fuses};
        bus(1'b1, IVX_IDX_MCU_CONTROL, 8'h01);
        bus(1'b1, IVX_IDX_MCU_CONTROL, 8'h02);
        tick(8);
        check(irq_req, 0);
        @(posedge clk_sys);
        fuse.app_lock_bit <= 1'b0;
        tick(0);
        check(irq_req[1:0], 2'b11);
        complete_run;
    end
endmodule : test_irq_vector_place_ext_irq

//--- include/ivx_pkg.sv
// constants, register map and state types of the vector placement and external irq block
package ivx_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IVX_IDX_MCU_CONTROL   = 6'h35;
    localparam logic [5:0] IVX_IDX_SENSE_CTRL    = 6'h20;
    localparam logic [5:0] IVX_IDX_EXT_MASK      = 6'h21;
    localparam logic [5:0] IVX_IDX_EXT_FLAG      = 6'h22;
    localparam logic [5:0] IVX_IDX_PC_CTRL       = 6'h23;
    localparam logic [5:0] IVX_IDX_PC_FLAG       = 6'h24;
    localparam logic [5:0] IVX_IDX_PC_MASK0      = 6'h25;
    localparam logic [5:0] IVX_IDX_PC_MASK1      = 6'h26;
    localparam logic [5:0] IVX_IDX_PC_MASK2      = 6'h27;
    localparam logic [5:0] IVX_IDX_STATUS        = 6'h28;

    // mcu_control field positions
    localparam int IVX_BIT_VCE = 0;
    localparam int IVX_BIT_VSEL = 1;
    localparam int IVX_BIT_PUD = 4;

    // reset values
    localparam logic [7:0] IVX_RST_BYTE = 8'h00;
    localparam logic [23:0] IVX_RST_PC_MASK = 24'h00_0000;

    // sense encodings
    localparam logic [1:0] IVX_SENSE_LOW  = 2'b00;
    localparam logic [1:0] IVX_SENSE_ANY  = 2'b01;
    localparam logic [1:0] IVX_SENSE_FALL = 2'b10;
    localparam logic [1:0] IVX_SENSE_RISE = 2'b11;

    // request indices on irq_req and irq_ack_id
    localparam logic [2:0] IVX_REQ_EXT_A = 3'h0;
    localparam logic [2:0] IVX_REQ_EXT_B = 3'h1;
    localparam logic [2:0] IVX_REQ_PC0   = 3'h2;
    localparam logic [2:0] IVX_REQ_PC1   = 3'h3;
    localparam logic [2:0] IVX_REQ_PC2   = 3'h4;
    localparam int IVX_NUM_REQ = 5;

    // group 1 has no pin 15
    localparam logic [7:0] IVX_PC1_VALID = 8'h7F;

    // timing: change window in cpu cycles, instructions held after the select write
    localparam int IVX_VCE_CYCLES = 4;
    localparam logic [2:0] IVX_VCE_CNT_INIT = 3'(IVX_VCE_CYCLES);
    localparam logic [1:0] IVX_POST_INSTR = 2'h2;

    typedef struct packed {
        logic        global_irq_enable;
        logic        exec_in_boot;
        logic        instr_done;
        logic        irq_ack;
        logic [2:0]  irq_ack_id;
    } ivx_core_t;

    typedef struct packed {
        logic        app_lock_bit;
        logic        boot_lock_bit;
        logic [1:0]  boot_size_fuses;
    } ivx_fuse_t;

    typedef struct packed {
        logic        ack;
        logic [7:0]  rdata;
        logic        vector_select;
        logic        vector_change_enable;
        logic [2:0]  vce_cnt;
        logic [1:0]  post_cnt;
        logic        pullup_disable;
        logic [3:0]  sense;
        logic [1:0]  ext_en;
        logic [1:0]  ext_flag;
        logic [2:0]  pc_en;
        logic [2:0]  pc_flag;
        logic [23:0] pc_mask;
        logic [1:0]  ext_prev;
        logic [23:0] pc_prev;
        logic        primed;
    } ivx_state_t;

endpackage : ivx_pkg
